// ==== csr_core_regs.sv ====
// Purpose: Stack, dual data pointer and power control registers of the core
// Assumes: Core presents one access per cycle; inputs synchronous to i_clk
// Notes:   Unclaimed direct locations are handed out to user soft logic
//
// Function
// - Stack pointer resets to 07h; software may overwrite it freely.
// - Push increments stack pointer first, then writes the scratchpad entry.
// - Pop reads the addressed entry first, then decrements stack pointer.
// - Calls and interrupts push return address with pre-increment order.
// - Registers live at 80h-FFh and answer direct accesses only.
// - Single-bit access only where address low nibble is 0 or 8.
// - Unimplemented power control bits 5 and 4 read as ones.
// - Unused locations and the four port locations go to soft logic.
// - Both data pointer pairs reset to 00h.
// - Select bit 0 picks pair: 1 second pair, 0 primary pair.
// - Pointer instructions use and update only the selected pair.
// - Unused second pair behaves as plain read/write registers.
// - Select register bits 7 to 1 read as zero.
// - Select register resets to 00h, primary pair active.
// - Baud-double bit doubles serial rate in modes 1, 2, 3.
// - Frame-check enable turns serial control bit 7 into error flag.
// - Power control bits 3 and 2 are stored user flags.
// - Power-down bit stops all clocks and halts execution.
// - Idle bit stops only processor clock; peripherals keep running.
// - Power control resets to 00110000b.
// - All these registers are freely readable and writable.
// - Framing error flag set by invalid stop bit while frame check is enabled, cleared only by reset.
`include "csr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire csr_pkg::csr_req_t i_req,
   input  wire logic             i_direct,
   input  wire csr_pkg::csr_op_t i_op,
   input  wire logic             i_serial_mode_bit,
   input  wire logic             i_stop_bit_bad,
   input  wire logic             i_irq_taken,
   input  wire logic             i_wake,
   input  wire logic [7:0]       i_ext_rdata,
   output logic [7:0]            o_rdata,
   output logic                  o_ext_sel,
   output logic [7:0]            o_stack_addr,
   output logic                  o_stack_wr,
   output logic                  o_stack_rd,
   output logic [15:0]           o_active_data_pointer,
   output logic                  o_baud_double,
   output logic                  o_serial_ctrl_bit7,
   output logic                  o_frame_error_flag,
   output logic                  o_user_flag_1,
   output logic                  o_user_flag_0,
   output logic                  o_cpu_clk_en,
   output logic                  o_periph_clk_en,
   output logic                  o_power_down_option_en
);

   // ==========================================================
   // State
   csr_pkg::csr_state_t s_q;
   csr_pkg::csr_state_t s_d;

   logic       sfr_hit;
   logic       own_hit;
   logic       bit_ok;
   logic       wr_en;
   logic [7:0] wval;
   logic [7:0] cur;
   logic [7:0] stack_inc;
   logic [15:0] np;

   // ==========================================================
   // Decode
   always_comb begin
      // Direct-only space; indirect ops fall through to scratchpad
      sfr_hit = i_direct && i_req.addr[7];
      own_hit = sfr_hit && (i_req.addr >= `CSR_OFF_STACK) &&
                (i_req.addr <= `CSR_OFF_POWER);
      bit_ok  = (i_req.addr[3:0] == 4'h0) || (i_req.addr[3:0] == 4'h8);
      wr_en   = own_hit && i_req.wr && (!i_req.bit_op || bit_ok);
      case (i_req.addr)
         `CSR_OFF_STACK:    cur = s_q.stack;
         `CSR_OFF_DP0_LOW:  cur = s_q.dp0_low;
         `CSR_OFF_DP0_HIGH: cur = s_q.dp0_high;
         `CSR_OFF_DP1_LOW:  cur = s_q.dp1_low;
         `CSR_OFF_DP1_HIGH: cur = s_q.dp1_high;
         `CSR_OFF_PTR_SEL:  cur = {7'h00, s_q.ptr_sel};
         `CSR_OFF_POWER:    cur = s_q.power | `CSR_PWR_UNIMPL;
         default:           cur = 8'hff;
      endcase
      // Bit ops merge into current value so other bits stay put
      wval = i_req.wdata;
      if (i_req.bit_op) begin
         wval = cur;
         wval[i_req.bit_sel] = i_req.wdata[0];
      end
      stack_inc = s_q.stack + 8'h01;
   end

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      np  = 16'h0000;
      if (wr_en) begin
         case (i_req.addr)
            `CSR_OFF_STACK:    s_d.stack    = wval;
            `CSR_OFF_DP0_LOW:  s_d.dp0_low  = wval;
            `CSR_OFF_DP0_HIGH: s_d.dp0_high = wval;
            `CSR_OFF_DP1_LOW:  s_d.dp1_low  = wval;
            `CSR_OFF_DP1_HIGH: s_d.dp1_high = wval;
            `CSR_OFF_PTR_SEL:  s_d.ptr_sel  = wval[`CSR_SEL_BIT];
            `CSR_OFF_POWER:    s_d.power    = wval | `CSR_PWR_UNIMPL;
            default:           s_d.power    = s_q.power;
         endcase
      end
      // Push/call/interrupt: pointer moves before data is written
      if (i_op.push) begin
         s_d.stack = stack_inc;
      end else if (i_op.pop) begin
         s_d.stack = s_q.stack - 8'h01;
      end
      // Pointer updates touch only the selected pair
      if (i_op.ptr_load || i_op.ptr_inc) begin
         np = i_op.ptr_load ? i_op.ptr_val :
              (s_q.ptr_sel ? {s_q.dp1_high, s_q.dp1_low}
                           : {s_q.dp0_high, s_q.dp0_low}) + 16'h0001;
         if (s_q.ptr_sel) begin
            s_d.dp1_low  = np[7:0];
            s_d.dp1_high = np[15:8];
         end else begin
            s_d.dp0_low  = np[7:0];
            s_d.dp0_high = np[15:8];
         end
      end
      // Bad stop bit sets the flag while frame check is on; only reset clears it
      if (s_q.power[`CSR_PWR_FRM_CHK] && i_stop_bit_bad) begin
         s_d.frame_error_flag = 1'b1;
      end
      // Power state follows request bits
      case (s_q.pwr)
         csr_pkg::CSR_RUN: begin
            if (s_d.power[`CSR_PWR_PDOWN]) begin
               s_d.pwr = csr_pkg::CSR_PDOWN;
            end else if (s_d.power[`CSR_PWR_IDLE]) begin
               s_d.pwr = csr_pkg::CSR_IDLE;
            end
         end
         csr_pkg::CSR_IDLE: begin
            // External wake also clears a pending idle request
            if (i_irq_taken || i_wake) begin
               s_d.pwr = csr_pkg::CSR_RUN;
               s_d.power[`CSR_PWR_IDLE] = 1'b0;
            end
         end
         csr_pkg::CSR_PDOWN: begin
            if (i_wake) begin
               s_d.pwr = csr_pkg::CSR_RUN;
               s_d.power[`CSR_PWR_PDOWN] = 1'b0;
               s_d.power[`CSR_PWR_IDLE]  = 1'b0;
            end
         end
         default: s_d.pwr = csr_pkg::CSR_RUN;
      endcase
      // Read data registered; foreign locations come from soft logic
      s_d.rhit  = own_hit && i_req.rd;
      s_d.rdata = cur;
      if (i_rst) begin
         s_d.stack    = `CSR_RST_STACK;
         s_d.dp0_low  = `CSR_RST_ACTIVE_DATA_POINTER;
         s_d.dp0_high = `CSR_RST_ACTIVE_DATA_POINTER;
         s_d.dp1_low  = `CSR_RST_ACTIVE_DATA_POINTER;
         s_d.dp1_high = `CSR_RST_ACTIVE_DATA_POINTER;
         s_d.ptr_sel  = 1'b0;
         s_d.power    = `CSR_RST_POWER;
         s_d.frame_error_flag = 1'b0;
         s_d.pwr      = csr_pkg::CSR_RUN;
         s_d.rdata    = 8'h00;
         s_d.rhit     = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   // ==========================================================
   // Outputs
   always_comb begin
      // Soft logic decodes ports and empty slots itself
      o_ext_sel = sfr_hit && !own_hit;
      o_rdata   = s_q.rhit ? s_q.rdata : i_ext_rdata;
      // Push writes at incremented address; pop reads current address
      o_stack_addr = i_op.push ? stack_inc : s_q.stack;
      o_stack_wr   = i_op.push;
      o_stack_rd   = i_op.pop;
      o_active_data_pointer = s_q.ptr_sel ?
                              {s_q.dp1_high, s_q.dp1_low} :
                              {s_q.dp0_high, s_q.dp0_low};
      o_baud_double = s_q.power[`CSR_PWR_BAUD_DBL];
      o_frame_error_flag = s_q.frame_error_flag;
      o_serial_ctrl_bit7 = s_q.power[`CSR_PWR_FRM_CHK] ?
                           s_q.frame_error_flag : i_serial_mode_bit;
      o_user_flag_1 = s_q.power[`CSR_PWR_FLAG1];
      o_user_flag_0 = s_q.power[`CSR_PWR_FLAG0];
      o_cpu_clk_en  = (s_q.pwr == csr_pkg::CSR_RUN);
      o_periph_clk_en = (s_q.pwr != csr_pkg::CSR_PDOWN);
      o_power_down_option_en = (s_q.pwr == csr_pkg::CSR_PDOWN);
   end

endmodule // csr_core_regs
`default_nettype wire

// ==== csr_core_regs_chk.sv ====
// Purpose: Port checks of the core register bank
// Assumes: One clock, sync active-high reset
// Notes:   Core ops and writes kept apart in antecedents
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_chk (
   input wire logic              i_clk,
   input wire logic              i_rst,
   input wire csr_pkg::csr_req_t i_req,
   input wire logic              i_direct,
   input wire csr_pkg::csr_op_t  i_op,
   input wire logic              i_irq_taken,
   input wire logic              i_wake,
   input wire logic [7:0]        o_stack_addr,
   input wire logic              o_stack_wr,
   input wire logic              o_ext_sel,
   input wire logic [15:0]       o_active_data_pointer,
   input wire logic              o_baud_double,
   input wire logic              o_user_flag_1,
   input wire logic              o_cpu_clk_en,
   input wire logic              o_periph_clk_en,
   input wire logic              o_power_down_option_en
);
   // ==========================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic pw = i_req.wr && i_direct && !i_req.bit_op
                   && i_req.addr == 8'h87;
   wire logic qt = !i_irq_taken && !i_wake;
   rst_vals_a: assert property ($fell(i_rst) |-> o_cpu_clk_en
      && !o_baud_double && o_active_data_pointer == 16'h0000)
      else $error("reset values wrong");
   push_order_a: assert property (i_op.push |=> !i_op.push && !i_op.pop
      |-> o_stack_addr == $past(o_stack_addr)) else $error("push order");
   pop_order_a: assert property ((i_op.pop && !i_op.push) ##1
      (!i_op.push && !i_op.pop) |-> o_stack_addr == $past(o_stack_addr)
      - 8'h01) else $error("pop order");
   stack_wr_a: assert property (o_stack_wr == i_op.push)
      else $error("stack write strobe");
   ext_sel_a: assert property (i_direct && (i_req.rd || i_req.wr)
      |-> o_ext_sel == (i_req.addr[7] &&
      !(i_req.addr inside {[8'h81:8'h87]}))) else $error("export select");
   ptr_load_a: assert property (i_op.ptr_load && !i_req.wr |=>
      o_active_data_pointer == $past(i_op.ptr_val)) else $error("ptr load");
   ptr_inc_a: assert property (i_op.ptr_inc && !i_op.ptr_load &&
      !i_req.wr && !$past(i_req.wr) |=> o_active_data_pointer ==
      $past(o_active_data_pointer) + 16'h0001) else $error("ptr inc");
   pwr_flags_a: assert property (pw && qt |=>
      o_baud_double == $past(i_req.wdata[7]) &&
      o_user_flag_1 == $past(i_req.wdata[3])) else $error("power flags");
   idle_in_a: assert property (pw && qt && i_req.wdata[1:0] == 2'b01
      |=> !o_cpu_clk_en && o_periph_clk_en) else $error("idle entry");
   pdown_in_a: assert property (pw && !i_wake && i_req.wdata[1] |=>
      !o_periph_clk_en && o_power_down_option_en) else $error("pdown");
   wake_up_a: assert property (i_wake && !pw |=> o_cpu_clk_en)
      else $error("wake did not resume");
endmodule // csr_core_regs_chk
bind csr_core_regs csr_core_regs_chk chk_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_req(i_req), .i_direct(i_direct), .i_op(i_op),
   .i_irq_taken(i_irq_taken), .i_wake(i_wake),
   .o_stack_addr(o_stack_addr), .o_stack_wr(o_stack_wr),
   .o_ext_sel(o_ext_sel), .o_active_data_pointer(o_active_data_pointer),
   .o_baud_double(o_baud_double), .o_user_flag_1(o_user_flag_1),
   .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
   .o_power_down_option_en(o_power_down_option_en));
`default_nettype wire

// ==== csr_params.svh ====
// Purpose: Offsets, field positions and reset values of the core register bank
// Assumes: Direct address space is 8 bits wide
// Notes:   Included by the design, not by the package
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

`define CSR_SFR_BASE      8'h80
`define CSR_OFF_STACK     8'h81
`define CSR_OFF_DP0_LOW   8'h82
`define CSR_OFF_DP0_HIGH  8'h83
`define CSR_OFF_DP1_LOW   8'h84
`define CSR_OFF_DP1_HIGH  8'h85
`define CSR_OFF_PTR_SEL   8'h86
`define CSR_OFF_POWER     8'h87
`define CSR_OFF_PORT0     8'h80
`define CSR_OFF_PORT1     8'h90
`define CSR_OFF_PORT2     8'ha0
`define CSR_OFF_PORT3     8'hb0

`define CSR_RST_STACK     8'h07
`define CSR_RST_ACTIVE_DATA_POINTER      8'h00
`define CSR_RST_PTR_SEL   8'h00
`define CSR_RST_POWER     8'h30

`define CSR_PWR_BAUD_DBL  7
`define CSR_PWR_FRM_CHK   6
`define CSR_PWR_FLAG1     3
`define CSR_PWR_FLAG0     2
`define CSR_PWR_PDOWN     1
`define CSR_PWR_IDLE      0
`define CSR_PWR_UNIMPL    8'h30
`define CSR_SEL_BIT       0

`endif

// ==== csr_pkg.sv ====
// Purpose: Types shared by the core register bank
// Assumes: Constants come from csr_params.svh
// Notes:   Types only
`default_nettype none
package csr_pkg;

   // Register access request from the core
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       bit_op;
      logic [2:0] bit_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csr_req_t;

   // Stack and pointer operations from the core
   typedef struct packed {
      logic       push;
      logic       pop;
      logic       ptr_load;
      logic       ptr_inc;
      logic [15:0] ptr_val;
   } csr_op_t;

   typedef enum logic [1:0] {
      CSR_RUN   = 2'b00,
      CSR_IDLE  = 2'b01,
      CSR_PDOWN = 2'b10
   } csr_pwr_t;

   typedef struct packed {
      logic [7:0] stack;
      logic [7:0] dp0_low;
      logic [7:0] dp0_high;
      logic [7:0] dp1_low;
      logic [7:0] dp1_high;
      logic       ptr_sel;
      logic [7:0] power;
      logic       frame_error_flag;
      csr_pwr_t   pwr;
      logic [7:0] rdata;
      logic       rhit;
   } csr_state_t;

endpackage
`default_nettype wire

// ==== test_core_stack_active_data_pointer_power_sfrs.sv ====
// Purpose: Directed test of the core register bank
// Assumes: Inputs change at the falling edge
// Notes:   Reads check o_rdata one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module test_core_stack_active_data_pointer_power_sfrs;
   logic              i_clk = 1'b0, i_rst = 1'b1, i_direct = 1'b1;
   logic              i_serial_mode_bit = 1'b1, i_stop_bit_bad = 1'b0;
   logic              i_irq_taken = 1'b0, i_wake = 1'b0;
   logic [7:0]        i_ext_rdata = 8'ha5, o_rdata, o_stack_addr;
   csr_pkg::csr_req_t i_req = '0;
   csr_pkg::csr_op_t  i_op = '0;
   logic [15:0]       o_dp;
   logic              o_ext_sel, o_swr, o_srd, o_bd, o_sb7, o_fe, o_u1, o_u0;
   logic              o_cpu, o_per, o_pdo;
   int                mismatches = 0, compares = 0;
   logic [7:0]        rv [7] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30};
   logic [7:0]        wv [5] = '{8'hff, 8'h34, 8'h12, 8'hff, 8'h12};
   always #10 i_clk = ~i_clk;
   csr_core_regs dut (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
      .i_direct(i_direct), .i_op(i_op), .i_serial_mode_bit(i_serial_mode_bit),
      .i_stop_bit_bad(i_stop_bit_bad), .i_irq_taken(i_irq_taken),
      .i_wake(i_wake), .i_ext_rdata(i_ext_rdata), .o_rdata(o_rdata),
      .o_ext_sel(o_ext_sel), .o_stack_addr(o_stack_addr), .o_stack_wr(o_swr),
      .o_stack_rd(o_srd), .o_active_data_pointer(o_dp), .o_baud_double(o_bd),
      .o_serial_ctrl_bit7(o_sb7), .o_frame_error_flag(o_fe),
      .o_user_flag_1(o_u1), .o_user_flag_0(o_u0), .o_cpu_clk_en(o_cpu),
      .o_periph_clk_en(o_per), .o_power_down_option_en(o_pdo));
   // ==========================================
   // Tasks
   task automatic chk(input string what, input logic [15:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic r, w, b, input logic [7:0] a, d);
      @(negedge i_clk) i_req <= '{r, w, b, 3'h0, a, d};
      @(negedge i_clk) i_req <= '0;
   endtask
   task automatic wr(input logic [7:0] a, d);
      acc(1'b0, 1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, exp);
      acc(1'b1, 1'b0, 1'b0, a, 8'h00);
      chk("rdata", o_rdata, exp);
   endtask
   task automatic op(input csr_pkg::csr_op_t o, input logic [7:0] ea);
      @(negedge i_clk) i_op <= o;
      #1 chk("stack_addr", o_stack_addr, ea);
      chk("stack_strobes", {o_swr, o_srd}, {o.push, o.pop});
      @(negedge i_clk) i_op <= '0;
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (8) @(negedge i_clk);
      i_rst <= 1'b0;
      foreach (rv[k]) rd(8'(8'h81 + k), rv[k]);
      foreach (wv[k]) wr(8'(8'h81 + k), wv[k]);
      foreach (wv[k]) rd(8'(8'h81 + k), wv[k]);
      wr(8'h86, 8'hff);
      rd(8'h86, 8'h01);
      chk("active_data_pointer", o_dp, 16'h12ff);
      op('{ptr_inc: 1'b1, default: '0}, 8'hff);
      chk("active_data_pointer", o_dp, 16'h1300);
      rd(8'h82, 8'h34);
      wr(8'h86, 8'h00);
      chk("active_data_pointer", o_dp, 16'h1234);
      op('{ptr_load: 1'b1, ptr_val: 16'h0abc, default: '0}, 8'hff);
      rd(8'h83, 8'h0a);
      rd(8'h85, 8'h13);
      acc(1'b0, 1'b1, 1'b1, 8'h82, 8'h01);
      rd(8'h82, 8'hbc);
      i_direct = 1'b0; // Indirect path never hits a register
      wr(8'h81, 8'h55);
      i_direct = 1'b1;
      rd(8'h81, 8'hff);
      op('{push: 1'b1, default: '0}, 8'h00);
      rd(8'h81, 8'h00);
      op('{pop: 1'b1, default: '0}, 8'h00);
      rd(8'h81, 8'hff);
      @(negedge i_clk) i_req <= '{1'b1, 1'b0, 1'b0, 3'h0, 8'h90, 8'h00};
      #1 chk("ext", {o_ext_sel, o_rdata}, 9'h1a5);
      wr(8'h87, 8'hcc);
      rd(8'h87, 8'hfc);
      chk("flags", {o_bd, o_u1, o_u0}, 3'h7);
      @(negedge i_clk) i_stop_bit_bad <= 1'b1;
      @(negedge i_clk) i_stop_bit_bad <= 1'b0;
      i_serial_mode_bit = 1'b0;
      chk("bit7", {o_fe, o_sb7}, 2'h3);
      wr(8'h87, 8'h00);
      chk("bit7", o_sb7, 1'b0);
      wr(8'h87, 8'h01);
      chk("clocks", {o_cpu, o_per, o_pdo}, 3'h2);
      @(negedge i_clk) i_irq_taken <= 1'b1;
      @(negedge i_clk) i_irq_taken <= 1'b0;
      rd(8'h87, 8'h30);
      wr(8'h87, 8'h02);
      chk("clocks", {o_cpu, o_per, o_pdo}, 3'h1);
      @(negedge i_clk) i_irq_taken <= 1'b1;
      @(negedge i_clk) i_irq_taken <= 1'b0;
      chk("clocks", {o_cpu, o_per, o_pdo}, 3'h1);
      @(negedge i_clk) i_wake <= 1'b1;
      @(negedge i_clk) i_wake <= 1'b0;
      chk("clocks", {o_cpu, o_per, o_pdo}, 3'h6);
      i_rst = 1'b1; // Mid-run reset
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      rd(8'h81, 8'h07);
      tally_and_finish();
   end
   initial begin
      #100us;
      mismatches++;
      tally_and_finish();
   end
endmodule // test_core_stack_active_data_pointer_power_sfrs
`default_nettype wire
